/* otpif_mem_model.sv */
`default_nettype none
// Behavioural model of the one-time-programmable array behind the block.
module otpif_mem_model
	import otpif_pkg::*;
(
	input wire logic i_clk, // System clock.
	input wire logic [3:0] i_lat, // Cycles before the array answers.
	input wire otpif_mem_req_type i_req, // Request from the block.
	output logic o_done, // Operation finished, one cycle.
	output logic [31:0] o_rdata // Word read from the array.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:2047];
	logic [31:0] word_r = 32'h5a5a_0f0f;
	logic [3:0] cnt_r = 4'h0;
	assign o_rdata = word_r;
	// The read word toggles every cycle except a read completion, so stale data never looks valid.
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		word_r <= ~word_r;
		if ((i_req.rd || i_req.pgm) && !o_done) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r >= i_lat) begin
				cnt_r <= 4'h0;
				o_done <= 1'b1;
				if (i_req.pgm)
					mem[i_req.addr] <= i_req.wdata;
				else
					word_r <= mem[i_req.addr];
			end
		end
	end
endmodule
`default_nettype wire

/* otpif_pkg.sv */
`default_nettype none
package otpif_pkg;
	// Register bus geometry and memory geometry.
	localparam int OTPIF_BUS_AW = 5;
	localparam int OTPIF_DW = 32;
	localparam int OTPIF_LOC_W = 11;

	// Byte offsets of the sub-registers.
	localparam logic [4:0] OTPIF_OFS_PROGRAM_DATA_WORD = 5'h00;
	localparam logic [4:0] OTPIF_OFS_MEMORY_LOCATION_SELECT = 5'h04;
	localparam logic [4:0] OTPIF_OFS_MEMORY_OPERATION_CONTROL = 5'h06;
	localparam logic [4:0] OTPIF_OFS_MEMORY_OPERATION_STATE = 5'h08;
	localparam logic [4:0] OTPIF_OFS_FETCHED_DATA_WORD = 5'h0a;
	localparam logic [4:0] OTPIF_OFS_SPECIAL_FETCHED_WORD = 5'h0e;
	localparam logic [4:0] OTPIF_OFS_SPECIAL_FUNCTION_CONTROL = 5'h12;

	// Field positions in the control register.
	localparam int OTPIF_CTL_MANUAL_READ_ENABLE = 0;
	localparam int OTPIF_CTL_READ_TRIGGER = 1;
	localparam int OTPIF_CTL_PROGRAM_TRIGGER = 6;
	localparam int OTPIF_CTL_TUNING_VALUE_LOAD = 15;

	// Field positions in the status register.
	localparam int OTPIF_STA_PROGRAM_DONE = 0;
	localparam int OTPIF_STA_READ_DONE = 1;
	localparam int OTPIF_STA_BUSY = 2;

	// Reset values.
	localparam logic [31:0] OTPIF_RST_PROGRAM_DATA_WORD = 32'h0000_0000;
	localparam logic [15:0] OTPIF_RST_LOCATION = 16'h0000;
	localparam logic [15:0] OTPIF_RST_CONTROL = 16'h0000;
	localparam logic [31:0] OTPIF_RST_FETCHED = 32'h0000_0000;
	localparam logic [7:0] OTPIF_RST_SPECIAL_FUNCTION = 8'h00;

	// Request carried to the memory array.
	typedef struct packed {
		logic rd;
		logic pgm;
		logic [OTPIF_LOC_W-1:0] addr;
		logic [OTPIF_DW-1:0] wdata;
	} otpif_mem_req_type;

	// Sequencer states.
	typedef enum logic [1:0] {
		OTPIF_ST_IDLE = 2'b00,
		OTPIF_ST_READ = 2'b01,
		OTPIF_ST_PROG = 2'b10
	} otpif_state_type;
endpackage
`default_nettype wire

/* otpif_regs.sv */
// Added by the designer: the plain strobed port.
`default_nettype none
// Overview of operation
// - Registers give read and program memory access.
// - Sub-registers sit at their fixed byte offsets.
// - Low 11 address bits pick the location.
// - Upper five address bits are ignored.
// - Sixteen-bit control register clears on reset.
module otpif_regs
	import otpif_pkg::*;
(
	input wire logic i_clk, // System clock, 50 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic [OTPIF_BUS_AW-1:0] i_addr, // Register byte offset.
	input wire logic [31:0] i_wdata, // Register write data.
	input wire logic i_wr, // Write strobe.
	input wire logic i_rd, // Read strobe.
	output logic [31:0] o_rdata, // Read data, cycle after strobe.
	output otpif_mem_req_type o_mem_req, // Request to the array.
	input wire logic i_mem_done, // Array finished, same clock.
	input wire logic [OTPIF_DW-1:0] i_mem_rdata, // Word from the array.
	output logic o_tuning_load, // Tuning value load pulse.
	output logic [7:0] o_special_function // Special function setting.
);
	// Reset release chain.
	logic rst_meta_r;
	logic rst_sync_r;

	// Host-visible register storage.
	logic [31:0] program_data_word_r;
	logic [15:0] location_r;
	logic [15:0] control_r;
	logic [7:0] special_function_r;
	logic [31:0] special_fetched_r;

	// Sequencer handshake and status.
	logic prog_done_r;
	logic read_done_r;
	logic busy;
	logic read_done;
	logic prog_done;
	logic [OTPIF_DW-1:0] fetched_word;
	logic start_read;
	logic start_prog;
	logic [15:0] state_word;
	logic [31:0] rdata_nxt;

	// Reset release through two flip-flops.
	// The reset pin may rise at any point in the clock period.
	// Only the second flop feeds the rest of the block, so every register
	// leaves reset on the same edge and no half-released state is seen.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Data word to program; host fills it before the trigger.
	// The word is copied into the array request when the sequencer starts.
	// A write here while a program is in flight does not reach the array,
	// because the request is frozen for the whole operation.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			program_data_word_r <= OTPIF_RST_PROGRAM_DATA_WORD;
		end else if (i_wr && i_addr == OTPIF_OFS_PROGRAM_DATA_WORD) begin
			program_data_word_r <= i_wdata;
		end
	end

	// Location select; reserved upper bits are not stored.
	// Dropping the reserved bits at the write means they always read back
	// as zero and can never alias onto a different array location.
	// The stored index is sampled by the sequencer when an operation starts.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			location_r <= OTPIF_RST_LOCATION;
		end else if (i_wr && i_addr == OTPIF_OFS_MEMORY_LOCATION_SELECT) begin
			location_r <= {5'h00, i_wdata[OTPIF_LOC_W-1:0]};
		end
	end

	// Control register: triggers and load request clear themselves.
	// The trigger bits live for exactly one cycle after the write.
	// A trigger that lands while the sequencer is busy is therefore lost,
	// which keeps a second operation from starting on top of the first.
	// The manual read enable and the other stored bits keep their value
	// until the host writes the register again.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			control_r <= OTPIF_RST_CONTROL;
		end else if (i_wr && i_addr == OTPIF_OFS_MEMORY_OPERATION_CONTROL) begin
			control_r <= i_wdata[15:0];
		end else begin
			control_r[OTPIF_CTL_READ_TRIGGER] <= 1'b0;
			control_r[OTPIF_CTL_PROGRAM_TRIGGER] <= 1'b0;
			control_r[OTPIF_CTL_TUNING_VALUE_LOAD] <= 1'b0;
		end
	end

	// Special function register.
	// Only the low byte is stored; the rest of the bus word is ignored.
	// Its value is handed straight to the array side as a level.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			special_function_r <= OTPIF_RST_SPECIAL_FUNCTION;
		end else if (i_wr && i_addr == OTPIF_OFS_SPECIAL_FUNCTION_CONTROL) begin
			special_function_r <= i_wdata[7:0];
		end
	end

	// A trigger is taken only while the sequencer is idle.
	// Gating here, rather than in the sequencer alone, also keeps the
	// sticky done flags from being cleared by a trigger that is dropped.
	// When both triggers are set together the sequencer lets program win.
	assign start_read = control_r[OTPIF_CTL_READ_TRIGGER] && !busy;
	assign start_prog = control_r[OTPIF_CTL_PROGRAM_TRIGGER] && !busy;

	// Sequencer that holds one request to the array until it answers.
	// It runs from the synchronised reset like every register here except the two reset-chain flops.
	// Its completion pulses drive the status flags and the special word.
	otpif_seq u_seq (
		.i_clk(i_clk),
		.i_rst_n(rst_sync_r),
		.i_start_read(start_read),
		.i_start_prog(start_prog),
		.i_loc(location_r[OTPIF_LOC_W-1:0]),
		.i_wdata(program_data_word_r),
		.i_mem_done(i_mem_done),
		.i_mem_rdata(i_mem_rdata),
		.o_req(o_mem_req),
		.o_busy(busy),
		.o_read_done(read_done),
		.o_prog_done(prog_done),
		.o_rdata(fetched_word)
	);

	// Manual reads also land in the special word.
	// The copy is taken one cycle after the read finishes, when the
	// sequencer's read word already holds the new value.
	// Reads without the manual enable leave the special word untouched.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			special_fetched_r <= OTPIF_RST_FETCHED;
		end else if (read_done && control_r[OTPIF_CTL_MANUAL_READ_ENABLE]) begin
			special_fetched_r <= fetched_word;
		end
	end

	// Sticky done flags; a new start clears, a finish wins over it.
	// Each flag stays set until a trigger of its own kind is taken while the sequencer is idle.
	// Giving the finish priority means a completion that coincides with a
	// new start is never lost to software polling the status word.
	// A program never disturbs the read flag, and a read never the program flag.
	// A read trigger written together with a program trigger still clears the read flag, though program wins.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			prog_done_r <= 1'b0;
			read_done_r <= 1'b0;
		end else begin
			if (prog_done) begin
				prog_done_r <= 1'b1;
			end else if (start_prog) begin
				prog_done_r <= 1'b0;
			end
			if (read_done) begin
				read_done_r <= 1'b1;
			end else if (start_read) begin
				read_done_r <= 1'b0;
			end
		end
	end

	// Status word.
	// It is rebuilt every cycle from the flags and the sequencer state.
	// Unused bits always read as zero.
	always_comb begin
		state_word = 16'h0000;
		state_word[OTPIF_STA_PROGRAM_DONE] = prog_done_r;
		state_word[OTPIF_STA_READ_DONE] = read_done_r;
		state_word[OTPIF_STA_BUSY] = busy;
	end

	// Read decode; unmapped offsets read as zero.
	// Narrow registers are padded with zeros in their upper bits.
	// The decode has no side effects, so a read never disturbs an operation.
	// Reading an offset that is not mapped is harmless.
	always_comb begin
		case (i_addr)
			OTPIF_OFS_PROGRAM_DATA_WORD: rdata_nxt = program_data_word_r;
			OTPIF_OFS_MEMORY_LOCATION_SELECT: rdata_nxt = {16'h0000, location_r};
			OTPIF_OFS_MEMORY_OPERATION_CONTROL: rdata_nxt = {16'h0000, control_r};
			OTPIF_OFS_MEMORY_OPERATION_STATE: rdata_nxt = {16'h0000, state_word};
			OTPIF_OFS_FETCHED_DATA_WORD: rdata_nxt = fetched_word;
			OTPIF_OFS_SPECIAL_FETCHED_WORD: rdata_nxt = special_fetched_r;
			OTPIF_OFS_SPECIAL_FUNCTION_CONTROL: rdata_nxt = {24'h000000, special_function_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data register, valid only in the cycle after the strobe.
	// Returning to zero between reads keeps stale words off the bus,
	// so a master that samples one cycle late sees zero, not old data.
	// Back-to-back strobes each get their own answer cycle.
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// Outputs straight from registers, so they never glitch.
	// The load request is a single-cycle pulse after the control write.
	assign o_tuning_load = control_r[OTPIF_CTL_TUNING_VALUE_LOAD];
	assign o_special_function = special_function_r;
endmodule
`default_nettype wire

/* otpif_regs_checker.sv */
`default_nettype none
// Concurrent checks on the register block and its array link.
module otpif_regs_checker
	import otpif_pkg::*;
(
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Reset, active low.
	input wire logic [OTPIF_BUS_AW-1:0] i_addr, // Register offset.
	input wire logic [31:0] i_wdata, // Write data.
	input wire logic i_wr, // Write strobe.
	input wire logic i_rd, // Read strobe.
	input wire logic [31:0] o_rdata, // Read data.
	input wire otpif_mem_req_type o_mem_req, // Array request.
	input wire logic i_mem_done, // Array done.
	input wire logic [OTPIF_DW-1:0] i_mem_rdata, // Array word.
	input wire logic o_tuning_load, // Tuning load pulse.
	input wire logic [7:0] o_special_function // Special function.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] data_r;
	logic [31:0] word_r;
	logic [10:0] loc_r;
	logic act;
	logic ctl_wr;
	assign act = o_mem_req.rd | o_mem_req.pgm;
	assign ctl_wr = i_wr && i_addr == OTPIF_OFS_MEMORY_OPERATION_CONTROL;
	// Shadow copies of the program word, the location and the last fetched word.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_r <= 32'h0;
			word_r <= 32'h0;
			loc_r <= 11'h0;
		end else begin
			if (i_wr && i_addr == OTPIF_OFS_PROGRAM_DATA_WORD)
				data_r <= i_wdata;
			if (i_wr && i_addr == OTPIF_OFS_MEMORY_LOCATION_SELECT)
				loc_r <= i_wdata[10:0];
			if (o_mem_req.rd && i_mem_done)
				word_r <= i_mem_rdata;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside answer");
	AST_TRIG_REQ: assert property (ctl_wr && i_wdata[1] && !i_wdata[6] && !act |-> ##2 o_mem_req.rd)
		else $error("read request late");
	AST_REQ_ADDR: assert property (act |-> o_mem_req.addr == loc_r)
		else $error("request location wrong");
	AST_REQ_HOLD: assert property (act && !i_mem_done |=> act && $stable(o_mem_req))
		else $error("request changed before done");
	AST_REQ_DROP: assert property (act && i_mem_done |=> !act)
		else $error("request held after done");
	AST_FETCH: assert property ($past(i_rd && i_addr == OTPIF_OFS_FETCHED_DATA_WORD) |-> o_rdata == word_r)
		else $error("fetched word wrong");
	AST_PGM_WORD: assert property (o_mem_req.pgm |-> o_mem_req.wdata == data_r)
		else $error("program word wrong");
	AST_TUNE: assert property (ctl_wr && i_wdata[15] |=> ##[0:1] o_tuning_load)
		else $error("tuning load missing");
	AST_SF: assert property ($past(i_wr && i_addr == OTPIF_OFS_SPECIAL_FUNCTION_CONTROL)
		|-> o_special_function == $past(i_wdata[7:0]))
		else $error("special function wrong");
	COV_READ: cover property (o_mem_req.rd && i_mem_done);
	COV_PGM: cover property (o_mem_req.pgm && i_mem_done);
	COV_TUNE: cover property (o_tuning_load);
endmodule
bind otpif_regs otpif_regs_checker u_otpif_regs_checker (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .o_mem_req, .i_mem_done, .i_mem_rdata, .o_tuning_load, .o_special_function);
`default_nettype wire

/* otpif_regs_end.sv */
`default_nettype none
`default_nettype wire

/* otpif_regs_tb_top.sv */
`default_nettype none
// Register-level tests of the memory interface block.
module otpif_regs_tb_top;
	import otpif_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [4:0] i_addr = 5'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] lat = 4'h0;
	logic [31:0] o_rdata;
	logic [31:0] mem_rdata;
	logic mem_done;
	logic o_tuning_load;
	logic [7:0] o_special_function;
	otpif_mem_req_type o_mem_req;
	int failures = 0;
	int compares = 0;
	localparam logic [4:0] A_CTL = OTPIF_OFS_MEMORY_OPERATION_CONTROL;
	localparam logic [4:0] A_LOC = OTPIF_OFS_MEMORY_LOCATION_SELECT;
	localparam logic [4:0] A_STA = OTPIF_OFS_MEMORY_OPERATION_STATE;
	localparam logic [4:0] A_FET = OTPIF_OFS_FETCHED_DATA_WORD;
	localparam logic [4:0] A_SPF = OTPIF_OFS_SPECIAL_FETCHED_WORD;
	localparam logic [4:0] A_SFC = OTPIF_OFS_SPECIAL_FUNCTION_CONTROL;
	localparam logic [4:0] A_DAT = OTPIF_OFS_PROGRAM_DATA_WORD;
	localparam logic [4:0] rst_addr [7] = '{A_DAT, A_LOC, A_CTL, A_STA, A_FET, A_SPF, A_SFC};
	otpif_regs u_otpif_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_mem_req(o_mem_req), .i_mem_done(mem_done), .i_mem_rdata(mem_rdata),
		.o_tuning_load(o_tuning_load), .o_special_function(o_special_function));
	otpif_mem_model u_otpif_mem_model (.i_clk(i_clk), .i_lat(lat), .i_req(o_mem_req), .o_done(mem_done),
		.o_rdata(mem_rdata));
	// Free-running 50 MHz clock.
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// One-cycle register read, data checked in the following cycle.
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	// Waits, bounded, for the array request to drop; looks 1 ns past each edge.
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge i_clk);
		#1;
		while ((o_mem_req.rd || o_mem_req.pgm) && n < 40) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n >= 40) begin
			failures++;
			$display("unexpected at %0t: array request never dropped", $time);
		end
	endtask
	// Starts an operation and waits for it to finish.
	task automatic op(input logic [31:0] ctl);
		wr(A_CTL, ctl);
		wait_idle();
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog against a hung handshake.
	initial begin
		#100us;
		failures++;
		summarize();
	end
	// Main test sequence.
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		foreach (rst_addr[i]) rd(rst_addr[i], 32'h0);
		wr(A_LOC, 32'h0000_ffff);
		rd(A_LOC, 32'h0000_07ff);
		wr(A_SFC, 32'h0000_01c3);
		rd(A_SFC, 32'h0000_00c3);
		chk({24'h0, o_special_function}, 32'h0000_00c3);
		wr(A_CTL, 32'h0000_3f00);
		rd(A_CTL, 32'h0000_3f00);
		wr(A_CTL, 32'h0000_0000);
		wr(5'h1c, 32'hffff_ffff);
		rd(5'h1c, 32'h0);
		// Full word loaded first; only test locations 0x012 and 0x013 are programmed.
		lat = 4'h6;
		wr(A_DAT, 32'hdead_beef);
		rd(A_DAT, 32'hdead_beef);
		wr(A_LOC, 32'h0000_f812);
		op(32'h0000_0040);
		rd(A_STA, 32'h0000_0001);
		rd(A_CTL, 32'h0);
		lat = 4'h0;
		op(32'h0000_0003);
		rd(A_FET, 32'hdead_beef);
		rd(A_SPF, 32'hdead_beef);
		wr(A_DAT, 32'h1234_5678);
		wr(A_LOC, 32'h0000_0013);
		op(32'h0000_0040);
		rd(A_FET, 32'hdead_beef);
		op(32'h0000_0002);
		rd(A_FET, 32'h1234_5678);
		rd(A_STA, 32'h0000_0003);
		// A slow read shows busy, clears the read-done flag and holds its request.
		lat = 4'h6;
		wr(A_CTL, 32'h0000_0002);
		rd(A_STA, 32'h0000_0005);
		chk({31'h0, o_mem_req.rd}, 32'h0000_0001);
		chk({21'h0, o_mem_req.addr}, 32'h0000_0013);
		wait_idle();
		rd(A_STA, 32'h0000_0003);
		rd(A_FET, 32'h1234_5678);
		wr(A_CTL, 32'h0000_8000);
		#1 chk({31'h0, o_tuning_load}, 32'h0000_0001);
		@(posedge i_clk);
		#1 chk({31'h0, o_tuning_load}, 32'h0000_0000);
		repeat (3) @(posedge i_clk);
		summarize();
	end
endmodule
`default_nettype wire

/* otpif_seq.sv */
`default_nettype none
module otpif_seq
	import otpif_pkg::*;
(
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Synchronised reset, active low.
	input wire logic i_start_read, // Start a read, one cycle.
	input wire logic i_start_prog, // Start a program, one cycle.
	input wire logic [OTPIF_LOC_W-1:0] i_loc, // Location index.
	input wire logic [OTPIF_DW-1:0] i_wdata, // Word to program.
	input wire logic i_mem_done, // Array finished the operation.
	input wire logic [OTPIF_DW-1:0] i_mem_rdata, // Word from the array.
	output otpif_mem_req_type o_req, // Request to the array.
	output logic o_busy, // Operation in flight.
	output logic o_read_done, // Read finished, one cycle.
	output logic o_prog_done, // Program finished, one cycle.
	output logic [OTPIF_DW-1:0] o_rdata // Captured read word.
);
	otpif_state_type state_r;
	otpif_state_type state_nxt;
	otpif_mem_req_type req_r;

	// Next state: a started operation waits for the array to finish.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			OTPIF_ST_IDLE: begin
				if (i_start_prog) begin
					state_nxt = OTPIF_ST_PROG;
				end else if (i_start_read) begin
					state_nxt = OTPIF_ST_READ;
				end
			end
			OTPIF_ST_READ, OTPIF_ST_PROG: begin
				if (i_mem_done) begin
					state_nxt = OTPIF_ST_IDLE;
				end
			end
			default: state_nxt = OTPIF_ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= OTPIF_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Request held steady to the array for the whole operation.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_r <= '0;
		end else if (state_r == OTPIF_ST_IDLE) begin
			req_r.rd <= i_start_read && !i_start_prog;
			req_r.pgm <= i_start_prog;
			req_r.addr <= i_loc;
			req_r.wdata <= i_wdata;
		end else if (i_mem_done) begin
			req_r.rd <= 1'b0;
			req_r.pgm <= 1'b0;
		end
	end

	// Completion pulses and the read word, held until the next read.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_read_done <= 1'b0;
			o_prog_done <= 1'b0;
			o_rdata <= OTPIF_RST_FETCHED;
		end else begin
			o_read_done <= (state_r == OTPIF_ST_READ) && i_mem_done;
			o_prog_done <= (state_r == OTPIF_ST_PROG) && i_mem_done;
			if ((state_r == OTPIF_ST_READ) && i_mem_done) begin
				o_rdata <= i_mem_rdata;
			end
		end
	end

	assign o_req = req_r;
	assign o_busy = (state_r != OTPIF_ST_IDLE);
endmodule
`default_nettype wire
